// File: rtl/tuu_ea_check.sv
// Legality decode of the operand addressing field of the zero test.
`timescale 1ns/1ps
`default_nettype none

module tuu_ea_check (
  input wire logic [1:0] size,
  input wire logic [2:0] mode,
  input wire logic [2:0] rsel,
  input wire logic variant_late,
  output logic legal,
  output logic use_reg,
  output logic use_imm
);

  // Operand comes straight from a data or address register.
  assign use_reg = (mode == tuu_pkg::EA_DREG) || (mode == tuu_pkg::EA_AREG);

  // Operand is the immediate value that follows the opcode.
  assign use_imm = (mode == tuu_pkg::EA_EXT) && (rsel == tuu_pkg::EXT_IMM);

  // Mode and size legality; later core variants open up more modes.
  always_comb begin
    legal = 1'b0;
    if (size != tuu_pkg::SZ_BYTE && size != tuu_pkg::SZ_WORD && size != tuu_pkg::SZ_LONG) begin
      legal = 1'b0;
    end else begin
      case (mode)
        // Address register direct: word and long only, later variants only (see RULE8).
        tuu_pkg::EA_AREG: begin
          legal = variant_late && (size != tuu_pkg::SZ_BYTE);
        end
        tuu_pkg::EA_EXT: begin
          case (rsel)
            tuu_pkg::EXT_ABS_W: legal = 1'b1;
            tuu_pkg::EXT_ABS_L: legal = 1'b1;
            // Program counter relative forms are missing on early variants (see RULE9).
            tuu_pkg::EXT_PC_D16: legal = variant_late;
            tuu_pkg::EXT_PC_IDX: legal = variant_late;
            tuu_pkg::EXT_IMM: legal = variant_late;
            default: legal = 1'b0;
          endcase
        end
        // Data register direct and the memory indirect modes (see RULE7).
        default: begin
          legal = 1'b1;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// File: rtl/tuu_exec.sv
// Executor for the zero test, frame release and BCD expand instructions.
// How it works
// (RULE1) Negative flag follows operand top bit.
// (RULE2) Zero flag set when sized operand zero.
// (RULE3) Extend kept; overflow and carry cleared.
// (RULE4) Zero test never writes its operand.
// (RULE5) Bits 7..6 choose byte, word, long.
// (RULE6) Upper byte 01001010 marks zero test.
// (RULE7) Mode and register fields locate operand.
// (RULE8) Address register operand: later, word/long.
// (RULE9) No PC-relative operand on early variants.
// (RULE10) Frame release copies pointer to stack.
// (RULE11) Pop long into pointer, stack plus four.
// (RULE12) Low three bits pick the pointer.
// (RULE13) Frame release keeps all flags.
// (RULE14) Digits go to bits 11..8, 3..0.
// (RULE15) Adjustment word added before storing.
// (RULE16) BCD expand keeps all flags.
// (RULE17) Register form: low byte to low word.
// (RULE18) Register form keeps destination upper word.
// (RULE19) Memory form reads byte at predecremented source.
// (RULE20) Memory form writes high byte first, lower.
// (RULE21) Mode bit zero: data register form.
// (RULE22) Mode bit one: predecrement memory form.
`timescale 1ns/1ps
`default_nettype none

module tuu_exec (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [15:0] opcode,
  input wire logic [15:0] ext_word,
  input wire logic [31:0] imm_data,
  input wire logic [31:0] ea_addr,
  input wire logic variant_late,
  input wire logic [4:0] ccr_in,
  output logic [3:0] rf_rd_idx,
  input wire logic [31:0] rf_rd_data,
  output logic rf_we,
  output logic [3:0] rf_widx,
  output logic [31:0] rf_wdata,
  output logic ccr_we,
  output logic [4:0] ccr_out,
  output logic mem_req,
  output logic mem_we,
  output logic [1:0] mem_size,
  output logic [31:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  output logic busy,
  output logic done,
  output logic illegal
);

  // Whole sequencer state, registered as one word.
  typedef struct packed {
    tuu_pkg::tuu_state_e_t st;
    tuu_pkg::tuu_op_t op;
    logic [15:0] ir;
    logic [15:0] ext;
    logic [31:0] tmp;
    logic rf_we;
    logic [3:0] rf_widx;
    logic [31:0] rf_wdata;
    logic ccr_we;
    logic [4:0] ccr_out;
    logic mem_req;
    logic mem_we;
    logic [1:0] mem_size;
    logic [31:0] mem_addr;
    logic [7:0] mem_wdata;
    logic done;
    logic illegal;
  } tuu_state_t;

  tuu_state_t s;
  tuu_state_t next_s;

  // Operand legality results from the addressing decode.
  logic ea_legal;
  logic ea_reg;
  logic ea_imm;

  // Sized sign and zero test; shared by register, immediate and memory operands.
  function automatic logic [4:0] test_flags(input logic [31:0] v, input logic [1:0] sz,
                                            input logic xin);
    logic n;
    logic z;
    n = 1'b0;
    z = 1'b0;
    case (sz)
      tuu_pkg::SZ_BYTE: begin
        n = v[7];
        z = (v[7:0] == 8'h00);
      end
      tuu_pkg::SZ_WORD: begin
        n = v[15];
        z = (v[15:0] == 16'h0000);
      end
      default: begin
        n = v[31];
        z = (v == 32'h0000_0000);
      end
    endcase
    // Extend passes through, overflow and carry forced low (see RULE1) (see RULE2) (see RULE3).
    test_flags = {xin, n, z, 1'b0, 1'b0};
  endfunction

  // Spread two packed digits over two bytes with zero upper nibbles.
  function automatic logic [15:0] bcd_spread(input logic [7:0] b);
    bcd_spread = {4'h0, b[7:4], 4'h0, b[3:0]};  // see RULE14
  endfunction

  // Addressing legality for the zero test operand.
  tuu_ea_check u_ea (
    .size(s.ir[tuu_pkg::SIZE_LSB +: 2]),
    .mode(s.ir[tuu_pkg::MODE_LSB +: 3]),
    .rsel(s.ir[2:0]),
    .variant_late(variant_late),
    .legal(ea_legal),
    .use_reg(ea_reg),
    .use_imm(ea_imm)
  );

  // Next-state logic; register reads are combinational against the core file.
  always_comb begin
    next_s = s;
    next_s.rf_we = 1'b0;
    next_s.ccr_we = 1'b0;  // Only the zero test raises it (see RULE13) (see RULE16).
    next_s.done = 1'b0;
    next_s.illegal = 1'b0;
    rf_rd_idx = 4'h0;
    case (s.st)
      // Accept an instruction and classify it.
      tuu_pkg::TUU_IDLE: begin
        if (start) begin
          next_s.ir = opcode;
          next_s.ext = ext_word;
          next_s.st = tuu_pkg::TUU_EXEC;
          if (opcode[15:8] == tuu_pkg::TEST_HI_BYTE) begin
            next_s.op = tuu_pkg::TUU_OP_TEST;  // see RULE6
          end else if ((opcode & tuu_pkg::FREL_MASK) == tuu_pkg::FREL_VALUE) begin
            next_s.op = tuu_pkg::TUU_OP_FREL;
          end else if ((opcode & tuu_pkg::BCDX_MASK) == tuu_pkg::BCDX_VALUE) begin
            next_s.op = tuu_pkg::TUU_OP_BCDX;
          end else begin
            // Anything else is not ours; report it and stay idle.
            next_s.op = tuu_pkg::TUU_OP_NONE;
            next_s.st = tuu_pkg::TUU_IDLE;
            next_s.illegal = 1'b1;
            next_s.done = 1'b1;
          end
        end
      end
      // First execution step for every kind.
      tuu_pkg::TUU_EXEC: begin
        case (s.op)
          tuu_pkg::TUU_OP_TEST: begin
            rf_rd_idx = {s.ir[tuu_pkg::MODE_LSB], s.ir[2:0]};
            if (!ea_legal) begin
              next_s.illegal = 1'b1;
              next_s.done = 1'b1;
              next_s.st = tuu_pkg::TUU_IDLE;
            end else if (ea_reg || ea_imm) begin
              // Flags only; nothing is written back (see RULE4).
              next_s.ccr_we = 1'b1;
              next_s.ccr_out = test_flags(ea_reg ? rf_rd_data : imm_data,
                                          s.ir[tuu_pkg::SIZE_LSB +: 2], ccr_in[tuu_pkg::CC_X]);
              next_s.done = 1'b1;
              next_s.st = tuu_pkg::TUU_IDLE;
            end else begin
              // Memory operand at the address the core's operand unit resolved (see RULE7).
              next_s.mem_req = 1'b1;
              next_s.mem_we = 1'b0;
              next_s.mem_addr = ea_addr;
              next_s.mem_size = s.ir[tuu_pkg::SIZE_LSB +: 2];  // see RULE5
              next_s.st = tuu_pkg::TUU_MEM;
            end
          end
          tuu_pkg::TUU_OP_FREL: begin
            // Stack pointer takes the chosen pointer, pop from it (see RULE10) (see RULE12).
            rf_rd_idx = {1'b1, s.ir[2:0]};
            next_s.tmp = rf_rd_data;
            next_s.rf_we = 1'b1;
            next_s.rf_widx = tuu_pkg::SP_IDX;
            next_s.rf_wdata = rf_rd_data;
            next_s.mem_req = 1'b1;
            next_s.mem_we = 1'b0;
            next_s.mem_addr = rf_rd_data;
            next_s.mem_size = tuu_pkg::SZ_LONG;
            next_s.st = tuu_pkg::TUU_MEM;
          end
          default: begin
            if (!s.ir[tuu_pkg::RM_BIT]) begin
              // Register form: hold the source data register (see RULE21).
              rf_rd_idx = {1'b0, s.ir[2:0]};
              next_s.tmp = rf_rd_data;
              next_s.st = tuu_pkg::TUU_STEP2;
            end else begin
              // Memory form: step source pointer down, fetch a byte (see RULE19) (see RULE22).
              rf_rd_idx = {1'b1, s.ir[2:0]};
              next_s.rf_we = 1'b1;
              next_s.rf_widx = {1'b1, s.ir[2:0]};
              next_s.rf_wdata = rf_rd_data - tuu_pkg::BYTE_STEP;
              next_s.mem_req = 1'b1;
              next_s.mem_we = 1'b0;
              next_s.mem_addr = rf_rd_data - tuu_pkg::BYTE_STEP;
              next_s.mem_size = tuu_pkg::SZ_BYTE;
              next_s.st = tuu_pkg::TUU_MEM;
            end
          end
        endcase
      end
      // Wait for a read to be answered.
      tuu_pkg::TUU_MEM: begin
        if (mem_ack) begin
          next_s.mem_req = 1'b0;
          case (s.op)
            tuu_pkg::TUU_OP_TEST: begin
              next_s.ccr_we = 1'b1;
              next_s.ccr_out = test_flags(mem_rdata, s.mem_size, ccr_in[tuu_pkg::CC_X]);
              next_s.done = 1'b1;
              next_s.st = tuu_pkg::TUU_IDLE;
            end
            tuu_pkg::TUU_OP_FREL: begin
              // Popped long word lands in the pointer (see RULE11).
              next_s.rf_we = 1'b1;
              next_s.rf_widx = {1'b1, s.ir[2:0]};
              next_s.rf_wdata = mem_rdata;
              next_s.st = tuu_pkg::TUU_WB;
            end
            default: begin
              next_s.tmp = mem_rdata;
              next_s.st = tuu_pkg::TUU_STEP2;
            end
          endcase
        end
      end
      // Expand, adjust and deliver the BCD result.
      tuu_pkg::TUU_STEP2: begin
        if (!s.ir[tuu_pkg::RM_BIT]) begin
          // Destination keeps its upper word (see RULE15) (see RULE17) (see RULE18).
          rf_rd_idx = {1'b0, s.ir[tuu_pkg::DST_REG_LSB +: 3]};
          next_s.rf_we = 1'b1;
          next_s.rf_widx = {1'b0, s.ir[tuu_pkg::DST_REG_LSB +: 3]};
          next_s.rf_wdata = {rf_rd_data[31:16], bcd_spread(s.tmp[7:0]) + s.ext};
          next_s.done = 1'b1;
          next_s.st = tuu_pkg::TUU_IDLE;
        end else begin
          // Destination pointer drops by two; high-digit byte goes to the lower address.
          rf_rd_idx = {1'b1, s.ir[tuu_pkg::DST_REG_LSB +: 3]};
          next_s.tmp = {16'h0000, bcd_spread(s.tmp[7:0]) + s.ext};  // see RULE15
          next_s.rf_we = 1'b1;
          next_s.rf_widx = {1'b1, s.ir[tuu_pkg::DST_REG_LSB +: 3]};
          next_s.rf_wdata = rf_rd_data - tuu_pkg::PAIR_STEP;
          next_s.mem_req = 1'b1;
          next_s.mem_we = 1'b1;
          next_s.mem_size = tuu_pkg::SZ_BYTE;
          next_s.mem_addr = rf_rd_data - tuu_pkg::PAIR_STEP;
          next_s.mem_wdata = next_s.tmp[15:8];  // see RULE20
          next_s.st = tuu_pkg::TUU_WRHI;
        end
      end
      // Stack pointer moves past the popped word, after the pointer load.
      tuu_pkg::TUU_WB: begin
        next_s.rf_we = 1'b1;
        next_s.rf_widx = tuu_pkg::SP_IDX;
        next_s.rf_wdata = s.tmp + tuu_pkg::POP_STEP;  // see RULE11
        next_s.done = 1'b1;
        next_s.st = tuu_pkg::TUU_IDLE;
      end
      // High byte written; low byte follows at the next address.
      tuu_pkg::TUU_WRHI: begin
        if (mem_ack) begin
          next_s.mem_addr = s.mem_addr + tuu_pkg::BYTE_STEP;  // see RULE20
          next_s.mem_wdata = s.tmp[7:0];
          next_s.st = tuu_pkg::TUU_WRLO;
        end
      end
      tuu_pkg::TUU_WRLO: begin
        if (mem_ack) begin
          next_s.mem_req = 1'b0;
          next_s.mem_we = 1'b0;
          next_s.done = 1'b1;
          next_s.st = tuu_pkg::TUU_IDLE;
        end
      end
      default: begin
        next_s.st = tuu_pkg::TUU_IDLE;
      end
    endcase
  end

  // State register; the reset value keeps every output quiet.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
      s.st <= tuu_pkg::TUU_IDLE;
      s.op <= tuu_pkg::TUU_OP_NONE;
    end else begin
      s <= next_s;
    end
  end

  // Output wiring; busy is the only combinational handshake.
  assign busy = (s.st != tuu_pkg::TUU_IDLE);
  assign rf_we = s.rf_we;
  assign rf_widx = s.rf_widx;
  assign rf_wdata = s.rf_wdata;
  assign ccr_we = s.ccr_we;
  assign ccr_out = s.ccr_out;
  assign mem_req = s.mem_req;
  assign mem_we = s.mem_we;
  assign mem_size = s.mem_size;
  assign mem_addr = s.mem_addr;
  assign mem_wdata = s.mem_wdata;
  assign done = s.done;
  assign illegal = s.illegal;

  // Steps of a frame release as seen at the ports.
  sequence frel_sp_load;
    rf_we && (rf_widx == tuu_pkg::SP_IDX);
  endsequence
  sequence frel_pop_tail;
    rf_we && (rf_widx[3] == 1'b1) ##1 rf_we && (rf_widx == tuu_pkg::SP_IDX) && done;
  endsequence

  a_test_keeps_x: assert property (@(posedge ref_clk) disable iff (rst)  // see RULE3
    ccr_we |-> ccr_out[tuu_pkg::CC_X] == $past(ccr_in[tuu_pkg::CC_X]) &&
      !ccr_out[tuu_pkg::CC_V] && !ccr_out[tuu_pkg::CC_C])
    else $error("extend not kept or overflow/carry set");
  a_test_n_z: assert property (@(posedge ref_clk) disable iff (rst)  // see RULE2
    (s.st == tuu_pkg::TUU_MEM && s.op == tuu_pkg::TUU_OP_TEST && mem_ack &&
      s.mem_size == tuu_pkg::SZ_BYTE) |=> ccr_we &&
      ccr_out[tuu_pkg::CC_Z] == ($past(mem_rdata[7:0]) == 8'h00) &&
      ccr_out[tuu_pkg::CC_N] == $past(mem_rdata[7]))
    else $error("byte test flags wrong");
  a_test_read_only: assert property (@(posedge ref_clk) disable iff (rst)  // see RULE4
    (s.op == tuu_pkg::TUU_OP_TEST && busy) |-> !rf_we && !mem_we)
    else $error("zero test wrote a result");
  a_test_size_sel: assert property (@(posedge ref_clk) disable iff (rst)  // see RULE5
    (mem_req && s.op == tuu_pkg::TUU_OP_TEST) |-> mem_size == s.ir[7:6])
    else $error("test read size not from size field");
  a_flags_untouched: assert property (@(posedge ref_clk) disable iff (rst)  // see RULE13
    ccr_we |-> $past(s.op) == tuu_pkg::TUU_OP_TEST)
    else $error("flags written outside zero test");
  a_frel_sp_first: assert property (@(posedge ref_clk) disable iff (rst)  // see RULE10
    (start && !busy && (opcode & tuu_pkg::FREL_MASK) == tuu_pkg::FREL_VALUE) |-> ##2 frel_sp_load)
    else $error("stack pointer not loaded first");
  a_frel_pop: assert property (@(posedge ref_clk) disable iff (rst)  // see RULE11
    (s.st == tuu_pkg::TUU_MEM && s.op == tuu_pkg::TUU_OP_FREL && mem_ack) |=> frel_pop_tail)
    else $error("pop or stack step missing");
  a_bcdx_reg_result: assert property (@(posedge ref_clk) disable iff (rst)  // see RULE18
    (rf_we && done && s.op == tuu_pkg::TUU_OP_BCDX) |->
      rf_wdata[31:16] == $past(rf_rd_data[31:16]) &&
      rf_wdata[15:0] == bcd_spread(s.tmp[7:0]) + s.ext)
    else $error("register form result wrong");
  a_bcdx_byte_order: assert property (@(posedge ref_clk) disable iff (rst)  // see RULE20
    (s.st == tuu_pkg::TUU_WRHI && mem_ack) |=> mem_we && mem_addr == $past(mem_addr) + 32'h1 &&
      mem_wdata == s.tmp[7:0])
    else $error("low byte not at following address");

endmodule

`default_nettype wire

// File: rtl/tuu_pkg.sv
// Shared constants and types for the test, frame release and BCD expand executor.
package tuu_pkg;

  // Sequencer states, one-hot.
  typedef enum logic [6:0] {
    TUU_IDLE = 7'h01,
    TUU_EXEC = 7'h02,
    TUU_MEM = 7'h04,
    TUU_STEP2 = 7'h08,
    TUU_WB = 7'h10,
    TUU_WRHI = 7'h20,
    TUU_WRLO = 7'h40
  } tuu_state_e_t;

  // Instruction kinds accepted by the executor.
  typedef enum logic [1:0] {
    TUU_OP_NONE = 2'h0,
    TUU_OP_TEST = 2'h1,
    TUU_OP_FREL = 2'h2,
    TUU_OP_BCDX = 2'h3
  } tuu_op_t;

  // Opcode recognition patterns and masks.
  localparam logic [7:0] TEST_HI_BYTE = 8'h4a;
  localparam logic [15:0] FREL_MASK = 16'hfff8;
  localparam logic [15:0] FREL_VALUE = 16'h4e58;
  localparam logic [15:0] BCDX_MASK = 16'hf1f0;
  localparam logic [15:0] BCDX_VALUE = 16'h8180;

  // Opcode field positions.
  localparam int SIZE_LSB = 6;
  localparam int MODE_LSB = 3;
  localparam int DST_REG_LSB = 9;
  localparam int RM_BIT = 3;

  // Operand sizes, also used as the memory transfer size code.
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  // Effective address modes and mode-7 register codes.
  localparam logic [2:0] EA_DREG = 3'h0;
  localparam logic [2:0] EA_AREG = 3'h1;
  localparam logic [2:0] EA_EXT = 3'h7;
  localparam logic [2:0] EXT_ABS_W = 3'h0;
  localparam logic [2:0] EXT_ABS_L = 3'h1;
  localparam logic [2:0] EXT_PC_D16 = 3'h2;
  localparam logic [2:0] EXT_PC_IDX = 3'h3;
  localparam logic [2:0] EXT_IMM = 3'h4;

  // Register file index of the stack pointer and pointer step sizes.
  localparam logic [3:0] SP_IDX = 4'hf;
  localparam logic [31:0] POP_STEP = 32'h0000_0004;
  localparam logic [31:0] BYTE_STEP = 32'h0000_0001;
  localparam logic [31:0] PAIR_STEP = 32'h0000_0002;

  // Condition code bit positions.
  localparam int CC_X = 4;
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_V = 1;
  localparam int CC_C = 0;

endpackage

// File: verification/tb_test_unlink_unpack_exec.sv
// Self-checking bench for the zero test, frame release and BCD expand executor.
`timescale 1ns/1ps
`default_nettype none

module tb_test_unlink_unpack_exec;
  // One zero test case: opcode, operand, variant, expected flags, expected refusal.
  typedef struct packed {
    logic [15:0] op;
    logic [31:0] val;
    logic late;
    logic [4:0] cc;
    logic ill;
  } tuu_row_t;

  localparam tuu_row_t ROWS [17] = '{
    '{16'h4a01, 32'hffffff00, 1'b1, 5'h14, 1'b0}, '{16'h4a01, 32'h00000080, 1'b1, 5'h18, 1'b0},
    '{16'h4a41, 32'h00010000, 1'b1, 5'h14, 1'b0}, '{16'h4a41, 32'h00008000, 1'b1, 5'h18, 1'b0},
    '{16'h4a81, 32'h80000000, 1'b1, 5'h18, 1'b0}, '{16'h4a81, 32'h00000001, 1'b1, 5'h10, 1'b0},
    '{16'h4ac1, 32'h00000001, 1'b1, 5'h00, 1'b1}, '{16'h4a09, 32'h00000000, 1'b1, 5'h00, 1'b1},
    '{16'h4a49, 32'h00000000, 1'b1, 5'h14, 1'b0}, '{16'h4a49, 32'h00000000, 1'b0, 5'h00, 1'b1},
    '{16'h4a91, 32'h80000000, 1'b0, 5'h08, 1'b0}, '{16'h4aba, 32'h00000000, 1'b1, 5'h14, 1'b0},
    '{16'h4aba, 32'h00000000, 1'b0, 5'h00, 1'b1}, '{16'h4abc, 32'h00000001, 1'b1, 5'h10, 1'b0},
    '{16'h0000, 32'h00000000, 1'b1, 5'h00, 1'b1},
    '{16'h4a38, 32'h00ffffff, 1'b0, 5'h04, 1'b0}, '{16'h4a79, 32'h80000000, 1'b1, 5'h18, 1'b0}};

  logic ref_clk = 1'b0;
  logic rst, start, variant_late, rf_we, ccr_we, mem_req, mem_we, mem_ack, busy, done, illegal;
  logic [15:0] opcode, ext_word;
  logic [31:0] imm_data, ea_addr, rf_rd_data, rf_wdata, mem_addr, mem_rdata;
  logic [4:0] ccr_in, ccr_out, got_cc;
  logic [3:0] rf_rd_idx, rf_widx, ack_delay;
  logic [1:0] mem_size;
  logic [7:0] mem_wdata;
  logic got_ill, got_ccw;
  // Writes seen during one instruction, and the run's tallies.
  int n_rfw, n_ccw, n_mw, cyc;
  int mismatches = 0;
  int n_compared = 0;

  always #12.5 ref_clk = ~ref_clk;

  tuu_exec dut_u (.ref_clk(ref_clk), .rst(rst), .start(start), .opcode(opcode),
    .ext_word(ext_word), .imm_data(imm_data), .ea_addr(ea_addr), .variant_late(variant_late),
    .ccr_in(ccr_in), .rf_rd_idx(rf_rd_idx), .rf_rd_data(rf_rd_data), .rf_we(rf_we),
    .rf_widx(rf_widx), .rf_wdata(rf_wdata), .ccr_we(ccr_we), .ccr_out(ccr_out),
    .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy),
    .done(done), .illegal(illegal));

  tuu_core_model partner_u (.ref_clk(ref_clk), .rst(rst), .ack_delay(ack_delay),
    .rf_rd_idx(rf_rd_idx), .rf_rd_data(rf_rd_data), .rf_we(rf_we), .rf_widx(rf_widx),
    .rf_wdata(rf_wdata), .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  // Tally every write strobe and the hang limit; a hang counts as a mismatch.
  always @(posedge ref_clk) begin
    cyc++;
    if (!rst) begin
      n_rfw += int'(rf_we);
      n_ccw += int'(ccr_we);
      n_mw += int'(mem_req && mem_we && mem_ack);
    end
    if (cyc == 4000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // Stores a long big-endian in the partner's memory.
  task automatic set_long(input logic [7:0] a, input logic [31:0] v);
    for (int k = 0; k < 4; k++) begin
      partner_u.mem[a + 8'(k)] = v[31 - 8 * k -: 8];
    end
  endtask

  // Issues one instruction from a falling edge, captures the done cycle, then idles a cycle
  // so that the write tallies include the last edge of the instruction.
  task automatic run(input logic [15:0] op, input logic [15:0] ext);
    int k;
    n_rfw = 0;
    n_ccw = 0;
    n_mw = 0;
    opcode = op;
    ext_word = ext;
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    for (k = 0; k < 200 && done !== 1'b1; k++) @(negedge ref_clk);
    chk_bit("done", 1'b1, done);
    got_ill = illegal;
    got_cc = ccr_out;
    got_ccw = ccr_we;
    @(negedge ref_clk);
  endtask

  // Frame release through one pointer; the stack pointer ends at the old pointer plus four.
  task automatic frel(input logic [2:0] r, input logic [31:0] a, input logic [31:0] v);
    partner_u.rf[{1'b1, r}] = a;
    set_long(a[7:0], v);
    run(16'h4e58 | {13'h0, r}, 16'h0000);
    chk_word("stack_ptr", a + 32'h4, partner_u.rf[15]);
    if (r != 3'h7) begin
      chk_word("frame_ptr_reg", v, partner_u.rf[{1'b1, r}]);
    end
    chk_word("flag_writes", 32'h0, 32'(n_ccw));
  endtask

  initial begin
    logic [7:0] b;
    logic [15:0] e;
    logic [31:0] want;
    rst = 1'b1;
    start = 1'b0;
    opcode = 16'h0000;
    ext_word = 16'h0000;
    imm_data = 32'h0;
    ea_addr = 32'h40;
    variant_late = 1'b1;
    ccr_in = 5'h13;
    ack_delay = 4'h0;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    chk_bit("busy", 1'b0, busy);
    chk_bit("mem_req", 1'b0, mem_req);
    $display("Test reset finished");
    // Zero test table: sizes, modes, variants and refusals; X comes from the variant bit.
    for (int i = 0; i < 17; i++) begin
      variant_late = ROWS[i].late;
      ccr_in = {ROWS[i].late, 4'h3};
      imm_data = ROWS[i].val;
      partner_u.rf[1] = ROWS[i].val;
      partner_u.rf[9] = ROWS[i].val;
      set_long(8'h40, ROWS[i].val);
      run(ROWS[i].op, 16'h0000);
      chk_bit("illegal", ROWS[i].ill, got_ill);
      chk_bit("flag_write", !ROWS[i].ill, got_ccw);
      if (!ROWS[i].ill) begin
        chk_word("flags", {27'h0, ROWS[i].cc}, {27'h0, got_cc});
      end
      chk_word("writes", 32'h0, 32'(n_rfw + n_mw));
    end
    $display("Test zero_test_op table finished");
    ack_delay = 4'h2;
    frel(3'h3, 32'h80, 32'h12345678);
    ack_delay = 4'h0;
    frel(3'h7, 32'h90, 32'haabbccdd);
    $display("Test frame_release_op finished");
    // Register form, one plain case and one where the adjustment wraps past 16 bits.
    for (int j = 0; j < 2; j++) begin
      b = (j == 0) ? 8'h47 : 8'h99;
      e = (j == 0) ? 16'h3030 : 16'hf7f7;
      partner_u.rf[5] = {24'h123456, b};
      partner_u.rf[2] = 32'hdeadbeef;
      run(16'h8585, e);
      want = {16'hdead, {4'h0, b[7:4], 4'h0, b[3:0]} + e};
      chk_word("dst_data_reg", want, partner_u.rf[2]);
      chk_word("flag_writes", 32'h0, 32'(n_ccw));
    end
    $display("Test bcd_expand_op register finished");
    // Memory form with a slow partner.
    ack_delay = 4'h3;
    partner_u.rf[9] = 32'h21;
    partner_u.rf[10] = 32'h32;
    partner_u.mem[8'h20] = 8'h59;
    run(16'h8589, 16'h3030);
    chk_word("src_ptr_reg", 32'h20, partner_u.rf[9]);
    chk_word("dst_ptr_reg", 32'h30, partner_u.rf[10]);
    chk_word("high_byte", 32'h35, {24'h0, partner_u.mem[8'h30]});
    chk_word("low_byte", 32'h39, {24'h0, partner_u.mem[8'h31]});
    chk_word("byte_writes", 32'h2, 32'(n_mw));
    chk_word("flag_writes", 32'h0, 32'(n_ccw));
    $display("Test bcd_expand_op memory finished");
    // Reset in the middle of a stalled frame release must drop the access at once.
    ack_delay = 4'h6;
    partner_u.rf[11] = 32'h80;
    opcode = 16'h4e5b;
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk_bit("busy", 1'b1, busy);
    rst = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    chk_bit("busy", 1'b0, busy);
    chk_bit("mem_req", 1'b0, mem_req);
    $display("Test midrun reset finished");
    complete_run();
  end
endmodule
`default_nettype wire

// File: verification/tuu_core_model.sv
// Register file and byte memory standing behind the executor's operand ports.
`timescale 1ns/1ps
`default_nettype none

module tuu_core_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] ack_delay,
  input wire logic [3:0] rf_rd_idx,
  output logic [31:0] rf_rd_data,
  input wire logic rf_we,
  input wire logic [3:0] rf_widx,
  input wire logic [31:0] rf_wdata,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  // Sixteen registers; index 15 is the stack pointer.
  logic [31:0] rf [16];
  // Small big-endian memory, decoded on the low address byte only.
  logic [7:0] mem [256];
  // Wait cycles spent on the current access.
  logic [3:0] cnt;
  // Data read out at the last completed access, whether a read or a write.
  logic [31:0] rd_q;
  logic [7:0] a;

  assign a = mem_addr[7:0];
  assign rf_rd_data = rf[rf_rd_idx];
  // Outside the ack cycle the read bus shows garbage, so stale data cannot pass.
  assign mem_rdata = mem_ack ? rd_q : ~rd_q;

  initial begin
    mem_ack = 1'b0;
    rd_q = 32'h0;
    cnt = 4'h0;
  end

  // Writes land one edge after the strobe; accesses finish after ack_delay waits.
  always @(posedge ref_clk) begin
    mem_ack <= 1'b0;
    if (rf_we) begin
      rf[rf_widx] <= rf_wdata;
    end
    if (rst) begin
      cnt <= 4'h0;
    end else if (mem_req && !mem_ack) begin
      if (cnt == ack_delay) begin
        cnt <= 4'h0;
        mem_ack <= 1'b1;
        if (mem_we) begin
          mem[a] <= mem_wdata;
        end
        case (mem_size)
          2'h0: rd_q <= {24'h0, mem[a]};
          2'h1: rd_q <= {16'h0, mem[a], mem[a + 8'h01]};
          default: rd_q <= {mem[a], mem[a + 8'h01], mem[a + 8'h02], mem[a + 8'h03]};
        endcase
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire
